// ---- logic/fom_cmd_decode.sv ----
`timescale 1ns/1ps
module fom_cmd_decode
    import fom_pkg::*;
(
    input wire logic [15:0] data,
    output logic legal,
    output logic to_status,
    output logic keep_sel
);
    // ------------------------------------------------------------
    // Command classification
    // ------------------------------------------------------------
    // Only the low byte carries the code; the block address word is full width
    always_comb begin
        legal = 1'b1;
        to_status = 1'b0;
        keep_sel = 1'b0;
        if (data == FOM_BLOCK_ADDR_WORD) begin
            legal = 1'b1;
        end else begin
            case (data[7:0])
                FOM_CMD_READ_ARRAY: legal = 1'b1;
                FOM_CMD_WORD_PGM_A, FOM_CMD_WORD_PGM_B, FOM_CMD_BP_SETUP, FOM_CMD_ERASE_SETUP,
                FOM_CMD_BUFFERED_FACTORY_PROGRAM_SETUP, FOM_CMD_READ_STATUS, FOM_CMD_LOCK_SETUP,
                FOM_CMD_OTP_SETUP: to_status = 1'b1;
                FOM_CMD_CONFIRM, FOM_CMD_SUSPEND, FOM_CMD_CLEAR_STATUS, FOM_CMD_LOCK_CONFIRM,
                FOM_CMD_LOCKDOWN_CONFIRM, FOM_CMD_CFG_CONFIRM: keep_sel = 1'b1;
                FOM_CMD_READ_ID, FOM_CMD_READ_QUERY: legal = 1'b1;
                default: begin
                    legal = 1'b0;
                    keep_sel = 1'b1;
                end
            endcase
        end
    end
endmodule

// ---- logic/fom_output_mux.sv ----
//------------------------------------------------------------
// Functional notes
// - In setup, load, confirm or factory verify states any write selects status.
// - Setup, read status, lock and OTP codes select status when ready/suspended/busy.
// - Confirm, suspend, clear status and lock confirms keep selection.
// - All-ones block address selects array; unknown codes keep selection.
// - Codes outside the command set are flagged illegal.
// - Array read from a busy partition returns invalid data.
// - ID and query data come from distinct addresses selected by address.
// - Erase setup then confirm while program suspended is ignored.
// - Clear status clears error bits only when no operation runs.
// - Factory program data accepted only while status bit zero is zero.
// - Each partition keeps its own selection; chip state ignores it.
// - Lock, unlock, lock-down, config confirms return chip to ready.
// - Block address of first cycle is latched as operation reference.
//------------------------------------------------------------
`timescale 1ns/1ps
module fom_output_mux
    import fom_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic [FOM_ADDR_W-1:0] wr_addr,
    input wire logic [FOM_PART_W-1:0] wr_part,
    input wire fom_chip_t chip_state,
    input wire logic pgm_suspended,
    input wire logic buffered_factory_program_mode,
    input wire logic sr_ready_bit0,
    input wire logic [FOM_SR_ERR_W-1:0] sr_err_set,
    input wire logic [FOM_NPART-1:0] part_busy,
    output logic [2*FOM_NPART-1:0] part_sel,
    output logic [FOM_NPART-1:0] part_invalid,
    output logic illegal_cmd,
    output logic ignore_cmd,
    output logic buffered_factory_program_data_ok,
    output logic ready_req,
    output logic [FOM_SR_ERR_W-1:0] sr_err,
    output logic [FOM_ADDR_W-1:0] first_cycle_block_address
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2*FOM_NPART-1:0] sel;
        logic [FOM_NPART-1:0] inval;
        logic illegal;
        logic ignore;
        logic buffered_factory_program_ok;
        logic ready;
        logic erase_pending;
        logic [FOM_SR_ERR_W-1:0] err;
        logic [FOM_ADDR_W-1:0] wa0;
    } fom_state_t;

    fom_state_t s_q;
    fom_state_t s_d;
    logic legal;
    logic to_status;
    logic keep_sel;
    logic [15:0] dec_data;
    logic [7:0] code;
    logic running;

    assign dec_data = wr_data;
    assign code = wr_data[7:0];

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Full word goes in, so the block address pattern is never taken for a read array
    fom_cmd_decode u_dec (
        .data(dec_data),
        .legal(legal),
        .to_status(to_status),
        .keep_sel(keep_sel)
    );

    // Operation in progress blocks error clearing
    function automatic logic is_running(input fom_chip_t st, input logic buffered_factory_program);
        is_running = (st == FOM_ST_BUSY) || (st == FOM_ST_OTP_BUSY) || buffered_factory_program;
    endfunction

    assign running = is_running(chip_state, buffered_factory_program_mode);

    // Second cycles that finish a lock or configuration setup
    function automatic logic is_lock_confirm(input logic [7:0] c);
        is_lock_confirm = (c == FOM_CMD_LOCK_CONFIRM) || (c == FOM_CMD_LOCKDOWN_CONFIRM) ||
            (c == FOM_CMD_CFG_CONFIRM) || (c == FOM_CMD_CONFIRM);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Chip state drives selection; the partition's current selection never feeds back
    always_comb begin
        fom_out_t nsel;
        logic upd;
        nsel = FOM_OUT_STATUS;
        upd = 1'b0;
        s_d = s_q;
        s_d.illegal = 1'b0;
        s_d.ignore = 1'b0;
        s_d.ready = 1'b0;
        s_d.buffered_factory_program_ok = 1'b0;
        // Errors: set always wins over clear
        s_d.err = s_q.err | sr_err_set;
        // Invalid data flag follows busy on array-selected partitions
        // Recomputed every enabled cycle so it drops at the first enabled edge after busy does
        for (int i = 0; i < FOM_NPART; i++) begin
            s_d.inval[i] = part_busy[i] && (fom_out_t'(s_q.sel[2*i +: 2]) == FOM_OUT_ARRAY);
        end
        if (wr_stb) begin
            if (buffered_factory_program_mode && wr_data != FOM_BLOCK_ADDR_WORD) begin
                // Factory data writes only go through while the ready bit is low
                s_d.buffered_factory_program_ok = !sr_ready_bit0;
                nsel = FOM_OUT_STATUS;
                upd = 1'b1;
            end else begin
                case (chip_state)
                    FOM_ST_SETUP: begin
                        nsel = FOM_OUT_STATUS;
                        upd = 1'b1;
                    end
                    FOM_ST_LOCK_SETUP: begin
                        // Only the configuration confirm hands the partition back to array reads
                        nsel = (code == FOM_CMD_CFG_CONFIRM) ? FOM_OUT_ARRAY : FOM_OUT_STATUS;
                        upd = 1'b1;
                        if (is_lock_confirm(code)) begin
                            s_d.ready = 1'b1;
                        end
                    end
                    FOM_ST_OTP_BUSY: begin
                        // Protection program runs to the end; the mux waits for it
                        upd = 1'b0;
                    end
                    default: begin
                        // Ready, suspended and busy states share one set of outcomes
                        if (wr_data == FOM_BLOCK_ADDR_WORD) begin
                            nsel = FOM_OUT_ARRAY;
                            upd = 1'b1;
                        end else if (code == FOM_CMD_READ_ARRAY) begin
                            nsel = FOM_OUT_ARRAY;
                            upd = 1'b1;
                        end else if (code == FOM_CMD_READ_ID || code == FOM_CMD_READ_QUERY) begin
                            // Address picks ID or query data within this window
                            nsel = FOM_OUT_IDQ;
                            upd = 1'b1;
                        end else if (to_status) begin
                            nsel = FOM_OUT_STATUS;
                            upd = 1'b1;
                        end else if (keep_sel) begin
                            // Confirm, suspend, clear status and unknown codes leave the mux alone
                            upd = 1'b0;
                        end
                    end
                endcase
                // Flagged in every state so the host can spot a stray code in a setup too
                s_d.illegal = !legal;
                // An error set in the same cycle survives the clear
                if (code == FOM_CMD_CLEAR_STATUS && !running) begin
                    s_d.err = sr_err_set;
                end
            end
            // Erase setup then confirm while program suspended: drop the confirm
            if (pgm_suspended && s_q.erase_pending && code == FOM_CMD_CONFIRM) begin
                s_d.ignore = 1'b1;
            end
            // Any other write in between ends the pairing
            s_d.erase_pending = pgm_suspended && (code == FOM_CMD_ERASE_SETUP);
            // First cycle of an operation latches the reference block
            if (chip_state == FOM_ST_READY || chip_state == FOM_ST_SUSPEND) begin
                if (to_status && code != FOM_CMD_READ_STATUS) begin
                    s_d.wa0 = wr_addr;
                end
            end
            // Only the addressed partition updates; host keeps both cycles in it
            if (upd) begin
                s_d.sel[2*wr_part +: 2] = nsel;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset: all partitions read array
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.sel <= {FOM_NPART{FOM_OUT_ARRAY}};
            s_q.inval <= '0;
            s_q.illegal <= 1'b0;
            s_q.ignore <= 1'b0;
            s_q.buffered_factory_program_ok <= 1'b0;
            s_q.ready <= 1'b0;
            s_q.erase_pending <= 1'b0;
            s_q.err <= FOM_SR_ERR_RST;
            s_q.wa0 <= FOM_ADDR_RST;
        end else if (clk_en) begin
            // Low enable holds every field, one-cycle flags included
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Straight from the state flops, so no decode glitch reaches the pins
    assign part_sel = s_q.sel;
    assign part_invalid = s_q.inval;
    assign illegal_cmd = s_q.illegal;
    assign ignore_cmd = s_q.ignore;
    assign buffered_factory_program_data_ok = s_q.buffered_factory_program_ok;
    assign ready_req = s_q.ready;
    assign sr_err = s_q.err;
    assign first_cycle_block_address = s_q.wa0;
endmodule

// ---- logic/fom_pkg.sv ----
package fom_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] FOM_CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] FOM_CMD_WORD_PGM_A = 8'h10;
    localparam logic [7:0] FOM_CMD_WORD_PGM_B = 8'h40;
    localparam logic [7:0] FOM_CMD_BP_SETUP = 8'he8;
    localparam logic [7:0] FOM_CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] FOM_CMD_BUFFERED_FACTORY_PROGRAM_SETUP = 8'h30;
    localparam logic [7:0] FOM_CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] FOM_CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] FOM_CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] FOM_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] FOM_CMD_READ_ID = 8'h90;
    localparam logic [7:0] FOM_CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] FOM_CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] FOM_CMD_OTP_SETUP = 8'hc0;
    localparam logic [7:0] FOM_CMD_LOCK_CONFIRM = 8'h01;
    localparam logic [7:0] FOM_CMD_LOCKDOWN_CONFIRM = 8'h2f;
    localparam logic [7:0] FOM_CMD_CFG_CONFIRM = 8'h03;
    localparam logic [15:0] FOM_BLOCK_ADDR_WORD = 16'hffff;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int FOM_NPART = 8;
    localparam int FOM_PART_W = 3;
    localparam int FOM_ADDR_W = 23;
    localparam int FOM_SR_ERR_W = 5;
    localparam logic [FOM_SR_ERR_W-1:0] FOM_SR_ERR_RST = 5'h00;
    localparam logic [FOM_ADDR_W-1:0] FOM_ADDR_RST = 23'h000000;

    // Output mux selection of one partition
    typedef enum logic [1:0] {
        FOM_OUT_ARRAY,
        FOM_OUT_IDQ,
        FOM_OUT_STATUS
    } fom_out_t;

    // Chip state class as seen by the output mux
    typedef enum logic [2:0] {
        FOM_ST_READY,
        FOM_ST_SETUP,
        FOM_ST_LOCK_SETUP,
        FOM_ST_BUSY,
        FOM_ST_SUSPEND,
        FOM_ST_OTP_BUSY
    } fom_chip_t;
endpackage

// ---- test/fom_host_model.sv ----
`timescale 1ns/1ps
// ------
// Host write port
// ------
module fom_host_model
    import fom_pkg::*;
(
    input wire logic clk,
    output logic wr_stb,
    output logic [15:0] wr_data,
    output logic [FOM_ADDR_W-1:0] wr_addr,
    output logic [FOM_PART_W-1:0] wr_part
);
    initial begin
        wr_stb = 1'b0;
        wr_data = 16'h0000;
        wr_addr = '0;
        wr_part = '0;
    end
    // One or two cycles; both cycles share partition and address
    task automatic wr(int n, logic [15:0] d1, logic [15:0] d2, logic [2:0] p, logic [22:0] a);
        @(negedge clk);
        wr_stb = 1'b1;
        wr_part = p;
        wr_addr = a;
        wr_data = d1;
        if (n > 1) begin
            @(negedge clk);
            wr_data = d2;
        end
        @(negedge clk);
        wr_stb = 1'b0;
        // Released bus shows no stale word
        wr_data = ~wr_data;
    endtask
endmodule

// ---- test/fom_output_mux_bench.sv ----
`timescale 1ns/1ps
// ------
// Random and corner command traffic
// ------
module fom_output_mux_bench;
    import fom_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic pgm_suspended = 1'b0;
    logic buffered_factory_program_mode = 1'b0;
    logic sr_ready_bit0 = 1'b0;
    logic [FOM_SR_ERR_W-1:0] sr_err_set = '0, sr_err;
    logic [FOM_NPART-1:0] part_busy = '0, part_invalid;
    fom_chip_t chip_state = FOM_ST_READY;
    logic wr_stb, illegal_cmd, ignore_cmd, buffered_factory_program_data_ok, ready_req;
    logic [15:0] wr_data, d;
    logic [FOM_ADDR_W-1:0] wr_addr, first_cycle_block_address;
    logic [FOM_PART_W-1:0] wr_part;
    logic [2*FOM_NPART-1:0] part_sel, sm;
    logic [31:0] seed = 32'h3c2c62a2, r;
    logic [7:0] code;
    logic il, rq;
    logic [7:0] codes [16] = '{8'hff, 8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'hd0, 8'hb0,
        8'h70, 8'h50, 8'h60, 8'hc0, 8'h01, 8'h2f, 8'h03, 8'h90};
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    fom_output_mux dut (.*);
    fom_host_model host (.*);
    always #2.5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected selection after one write
    function automatic fom_out_t exp_sel(fom_chip_t s, logic [15:0] x, fom_out_t o);
        if (s == FOM_ST_OTP_BUSY) return o;
        if (s == FOM_ST_SETUP) return FOM_OUT_STATUS;
        if (s == FOM_ST_LOCK_SETUP) return (x == 16'h0003) ? FOM_OUT_ARRAY : FOM_OUT_STATUS;
        if (x inside {16'hffff, 16'h00ff}) return FOM_OUT_ARRAY;
        if (x inside {16'h0090, 16'h0098}) return FOM_OUT_IDQ;
        if (x[7:0] inside {8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'h70, 8'h60, 8'hc0}) return FOM_OUT_STATUS;
        return o;
    endfunction
    // Busy partitions that point at array data read back garbage
    function automatic logic [FOM_NPART-1:0] exp_inv(logic [FOM_NPART-1:0] b, logic [2*FOM_NPART-1:0] s);
        for (int i = 0; i < FOM_NPART; i++) exp_inv[i] = b[i] && (s[2*i+:2] == 2'h0);
    endfunction
    task automatic chk(logic ok, string m);
        samples_checked++;
        if (!ok) begin
            fail_count++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic step(fom_chip_t s, logic [15:0] x, logic [2:0] p, logic [22:0] a);
        logic [FOM_NPART-1:0] inv;
        chip_state = s;
        inv = exp_inv(part_busy, sm);
        host.wr(1, x, x, p, a);
        if (clk_en) sm[2*p+:2] = exp_sel(s, x, fom_out_t'(sm[2*p+:2]));
        chk(part_sel === sm, "selection");
        if (clk_en) chk(part_invalid === inv, "invalid flag");
    endtask
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        sm = '0;
        chk(part_sel === '0 && sr_err === '0 && first_cycle_block_address === '0, "reset");
        for (int i = 0; i < 400; i++) begin
            r = xs();
            code = r[8] ? codes[r[15:12]] : r[23:16];
            d = (r[9] & r[10]) ? 16'hffff : {8'h00, code};
            clk_en = r[7:5] != 3'h0;
            part_busy = r[31:24];
            sr_ready_bit0 = r[11];
            step(fom_chip_t'(r[30:28] % 3'h6), d, r[2:0], r[22:0]);
            il = d != 16'hffff && !(code inside {codes, 8'h98});
            rq = chip_state == FOM_ST_LOCK_SETUP && d[7:0] inside {8'h01, 8'h2f, 8'h03, 8'hd0};
            if (clk_en) chk(illegal_cmd === il, "illegal flag");
            if (clk_en) chk(ready_req === rq, "ready request");
        end
        clk_en = 1'b1;
        // Erase setup then confirm while program is suspended
        chip_state = FOM_ST_SUSPEND;
        pgm_suspended = 1'b1;
        host.wr(2, 16'h0020, 16'h00d0, 3'h1, '0);
        chk(ignore_cmd === 1'b1, "confirm not dropped");
        sm[3:2] = FOM_OUT_STATUS;
        pgm_suspended = 1'b0;
        for (int i = 12; i < 15; i++) begin
            step(FOM_ST_LOCK_SETUP, {8'h00, codes[i]}, 3'h2, '0);
            chk(ready_req === 1'b1, "no ready request");
        end
        step(FOM_ST_READY, 16'h0020, 3'h3, 23'h5a5a5a);
        chk(first_cycle_block_address === 23'h5a5a5a, "address");
        step(FOM_ST_SUSPEND, 16'h0098, 3'h4, '0);
        step(FOM_ST_BUSY, 16'h0090, 3'h5, '0);
        sr_err_set = 5'h15;
        @(negedge clk);
        sr_err_set = '0;
        step(FOM_ST_BUSY, 16'h0050, 3'h3, '0);
        chk(sr_err === 5'h15, "cleared while busy");
        step(FOM_ST_READY, 16'h0050, 3'h3, '0);
        chk(sr_err === 5'h00, "not cleared");
        // Second reset mid-run
        rst_n = 1'b0;
        @(negedge clk);
        chk(part_sel === '0 && sr_err === '0, "reset");
        rst_n = 1'b1;
        chip_state = FOM_ST_BUSY;
        buffered_factory_program_mode = 1'b1;
        sr_ready_bit0 = 1'b1;
        host.wr(1, 16'h1234, 16'h1234, 3'h0, '0);
        chk(buffered_factory_program_data_ok === 1'b0, "data taken while busy");
        sr_ready_bit0 = 1'b0;
        host.wr(1, 16'h4321, 16'h4321, 3'h0, '0);
        chk(buffered_factory_program_data_ok === 1'b1, "data dropped");
        print_verdict();
    end
endmodule

// ---- test/fom_output_mux_props.sv ----
`timescale 1ns/1ps
// ------
// Selection, flag and ready request checks
// ------
module fom_output_mux_props
    import fom_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic [FOM_PART_W-1:0] wr_part,
    input wire fom_chip_t chip_state,
    input wire logic pgm_suspended,
    input wire logic buffered_factory_program_mode,
    input wire logic sr_ready_bit0,
    input wire logic [2*FOM_NPART-1:0] part_sel,
    input wire logic illegal_cmd,
    input wire logic ignore_cmd,
    input wire logic buffered_factory_program_data_ok,
    input wire logic ready_req
);
    logic [FOM_PART_W-1:0] lp_q;
    // Factory data writes follow their own rule, so they stay out of the command checks
    wire w = wr_stb && clk_en && !buffered_factory_program_mode;
    wire rc = chip_state inside {FOM_ST_READY, FOM_ST_SUSPEND, FOM_ST_BUSY};
    wire [7:0] c = wr_data[7:0];
    wire h0 = wr_data[15:8] == 8'h00;
    wire kn = c inside {8'hff, 8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'hd0, 8'hb0, 8'h70,
        8'h50, 8'h90, 8'h98, 8'h60, 8'hc0, 8'h01, 8'h2f, 8'h03};
    // Selection of the partition last written, seen one cycle later
    wire [1:0] ls = part_sel[2*lp_q+:2];
    always_ff @(posedge clk) lp_q <= wr_part;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_setup; w && chip_state == FOM_ST_SETUP |=> ls == FOM_OUT_STATUS; endproperty
    a_setup: assert property (p_setup) else $error("setup write kept selection");
    property p_cfg; w && chip_state == FOM_ST_LOCK_SETUP |=> ls == ($past(c) == 8'h03 ? 2'h0 : 2'h2); endproperty
    a_cfg: assert property (p_cfg) else $error("lock setup selection wrong");
    property p_stat;
        w && rc && h0 && c inside {8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'h70, 8'h60, 8'hc0} |=> ls == 2'h2;
    endproperty
    a_stat: assert property (p_stat) else $error("status not selected");
    property p_keep;
        w && rc && h0 && c inside {8'hd0, 8'hb0, 8'h50, 8'h01, 8'h2f, 8'h03} |=> $stable(part_sel);
    endproperty
    a_keep: assert property (p_keep) else $error("selection changed");
    property p_arr; w && rc && wr_data inside {16'hffff, 16'h00ff} |=> ls == FOM_OUT_ARRAY; endproperty
    a_arr: assert property (p_arr) else $error("array not selected");
    property p_idq; w && rc && h0 && c inside {8'h90, 8'h98} |=> ls == FOM_OUT_IDQ; endproperty
    a_idq: assert property (p_idq) else $error("id/query not selected");
    property p_ill; w && rc && h0 && !kn |=> illegal_cmd && $stable(part_sel); endproperty
    a_ill: assert property (p_ill) else $error("unknown code mishandled");
    property p_ign; w && h0 && c == 8'h20 && pgm_suspended ##1 w && h0 && c == 8'hd0 |=> ignore_cmd; endproperty
    a_ign: assert property (p_ign) else $error("confirm not dropped");
    property p_buffered_factory_program; wr_stb && clk_en && buffered_factory_program_mode && sr_ready_bit0 |=> !buffered_factory_program_data_ok; endproperty
    a_buffered_factory_program: assert property (p_buffered_factory_program) else $error("data taken while busy");
    property p_rdy;
        w && chip_state == FOM_ST_LOCK_SETUP && h0 && c inside {8'h01, 8'h2f, 8'h03} |=> ready_req;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready request");
    c_cfg: cover property (w && chip_state == FOM_ST_LOCK_SETUP);
    c_ign: cover property (ignore_cmd);
    c_buffered_factory_program: cover property (buffered_factory_program_data_ok);
    c_idq: cover property (w && rc && c == 8'h98);
endmodule
bind fom_output_mux fom_output_mux_props u_props (.*);
